// >>> flash_block_protect_program_control_bench.sv
// Self-checking bench for the flash protect and program sequencer.
`timescale 1ns/10ps
module flash_block_protect_program_control_bench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	flash_protect_pkg::array_access_t array_i;
	logic [7:0] protect_start_bits_i = 8'hFF;
	logic test_high_voltage_i = 1'b0;
	logic low_power_i = 1'b0;
	flash_protect_pkg::ctrl_t flash_ctrl_o;
	logic standby_o;
	logic go = 1'b0;
	logic [15:0] go_addr = 16'hC000;
	int fail_count = 0;
	int compares = 0;
	logic [31:0] rd;

	// Half period of 50 ns gives the 10 MHz clock.
	always #50 clk_i = ~clk_i;

	flash_protect_seq uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .array_i(array_i),
		.protect_start_bits_i(protect_start_bits_i), .test_high_voltage_i(test_high_voltage_i),
		.low_power_i(low_power_i), .flash_ctrl_o(flash_ctrl_o), .standby_o(standby_o));

	flash_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .addr_i(go_addr),
		.hv_i(flash_ctrl_o.hv), .array_o(array_i));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One classic cycle; the request is held until ack is sampled at a rising edge.
	// The wait has no limit of its own: only the watchdog ends a hung cycle.
	// The slave answers at the second edge after the request is raised.
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		check(32'(n), 32'h0000_0002, "ack latency");
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// One array write by the processor model.
	task automatic cpu_write(input logic [15:0] a);
		@(posedge clk_i);
		go <= 1'b1;
		go_addr <= a;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	// Full sequence up to high voltage, then checks whether high voltage was granted.
	task automatic attempt(input logic [3:0] sel, input logic [7:0] bits, input logic [15:0] a,
		input logic tv, input logic exp_hv);
		protect_start_bits_i <= bits;
		test_high_voltage_i <= tv;
		wb_cycle(1'b1, 8'h00, {28'h000_0000, sel});
		wb_cycle(1'b0, 8'h04, 32'h0000_0000);
		check(rd, {24'h00_0000, bits}, "protect byte read");
		cpu_write(a);
		wb_cycle(1'b0, 8'h0C, 32'h0000_0000);
		check(rd, {16'h0000, a}, "latched target");
		wb_cycle(1'b0, 8'h08, 32'h0000_0000);
		check(rd[6:0], {!exp_hv, 3'h0, 3'h3}, "status before hv");
		wb_cycle(1'b1, 8'h00, {28'h000_0000, sel | 4'h8});
		wb_cycle(1'b0, 8'h00, 32'h0000_0000);
		check(rd, {28'h000_0000, exp_hv, sel[2:0]}, "control after hv request");
		check(flash_ctrl_o.hv, exp_hv, "hv output");
		wb_cycle(1'b0, 8'h08, 32'h0000_0000);
		check(rd[4], !exp_hv, "refused flag");
		wb_cycle(1'b1, 8'h08, 32'h0000_0010);
		wb_cycle(1'b1, 8'h00, 32'h0000_0000);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic reset_state();
		wb_cycle(1'b0, 8'h00, 32'h0000_0000);
		check(rd, 32'h0000_0000, "control after reset");
		check({flash_ctrl_o, standby_o}, 5'h00, "outputs after reset");
	endtask

	task automatic protect_ranges();
		attempt(4'h1, 8'hFF, 16'hFFFF, 1'b0, 1'b1);
		attempt(4'h1, 8'h00, 16'hC000, 1'b0, 1'b0);
		attempt(4'h1, 8'h01, 16'hC03F, 1'b0, 1'b1);
		attempt(4'h2, 8'h01, 16'hC040, 1'b0, 1'b0);
		attempt(4'h1, 8'h80, 16'hDFFF, 1'b0, 1'b1);
		attempt(4'h2, 8'h80, 16'hFFFF, 1'b0, 1'b0);
		attempt(4'h1, 8'hFD, 16'hFF3F, 1'b0, 1'b1);
		attempt(4'h1, 8'hFD, 16'hFF40, 1'b0, 1'b0);
		attempt(4'h2, 8'hFE, 16'hFF7F, 1'b0, 1'b1);
		attempt(4'h2, 8'hFE, 16'hFF80, 1'b0, 1'b0);
		attempt(4'h1, 8'h00, 16'hC000, 1'b1, 1'b1);
	endtask

	// The test voltage is set by every attempt, so the first one here drops it again.
	task automatic mass_erase();
		attempt(4'h6, 8'hFE, 16'hC000, 1'b0, 1'b0);
		attempt(4'h6, 8'hFF, 16'hC000, 1'b0, 1'b1);
	endtask

	// The flag is cleared between the two refusals so that each one is seen on its own.
	task automatic interlock();
		wb_cycle(1'b1, 8'h00, 32'h0000_0003);
		wb_cycle(1'b0, 8'h00, 32'h0000_0000);
		check(rd, 32'h0000_0000, "both selects rejected");
		wb_cycle(1'b0, 8'h08, 32'h0000_0000);
		check(rd[4], 1'b1, "interlock refusal flagged");
		wb_cycle(1'b1, 8'h08, 32'h0000_0010);
		wb_cycle(1'b1, 8'h00, 32'h0000_0008);
		wb_cycle(1'b0, 8'h08, 32'h0000_0000);
		check({rd[4], flash_ctrl_o}, 5'h10, "hv without select refused");
		wb_cycle(1'b1, 8'h08, 32'h0000_0010);
	endtask

	task automatic abort_low_power();
		protect_start_bits_i <= 8'hFF;
		wb_cycle(1'b1, 8'h00, 32'h0000_0001);
		wb_cycle(1'b0, 8'h04, 32'h0000_0000);
		cpu_write(16'hC100);
		wb_cycle(1'b1, 8'h00, 32'h0000_0009);
		@(posedge clk_i);
		low_power_i <= 1'b1;
		@(posedge clk_i);
		low_power_i <= 1'b0;
		@(posedge clk_i);
		check({flash_ctrl_o, standby_o}, 5'h01, "standby after abort");
		wb_cycle(1'b0, 8'h08, 32'h0000_0000);
		check(rd[5], 1'b1, "standby status");
	endtask

	// A reset in mid-run must drop the standby flag left by the abort.
	task automatic mid_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({flash_ctrl_o, standby_o, wb_ack_o}, 6'h00, "outputs after second reset");
		reset_state();
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		reset_state();
		protect_ranges();
		mass_erase();
		interlock();
		abort_low_power();
		mid_reset();
		end_of_test();
	end

	initial begin
		#2000000;
		fail_count++;
		end_of_test();
	end
endmodule

// >>> flash_cpu_model.sv
// Processor-side model that issues the array writes of program and erase sequences.
`timescale 1ns/10ps
module flash_cpu_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Requests from the bench, and the high-voltage bit of the sequencer.
	input wire logic go_i,
	input wire logic [15:0] addr_i,
	input wire logic hv_i,
	// Array-side access.
	output flash_protect_pkg::array_access_t array_o
);
	// ----------------------------------------------------------------
	// Address screening
	// ----------------------------------------------------------------
	// Software only targets flash, never the reserved hole, never the watchdog under high voltage.
	logic addr_ok;
	assign addr_ok = (addr_i[15:14] == 2'h3)
		&& !(addr_i >= 16'hFFD4 && addr_i <= 16'hFFDF)
		&& !(hv_i && addr_i == 16'hFFFF);

	// ----------------------------------------------------------------
	// Array write
	// ----------------------------------------------------------------
	// One single-cycle write per request, issued in program order. Idle address lines toggle
	// so that a stale value is never mistaken for a live one. No interrupt traffic is modelled,
	// so nothing cuts into a running sequence.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			array_o <= '{wr: 1'b0, addr: 16'h5555};
		end else if (go_i && addr_ok) begin
			array_o <= '{wr: 1'b1, addr: addr_i};
		end else begin
			array_o <= '{wr: 1'b0, addr: ~array_o.addr};
		end
	end
endmodule

// >>> flash_protect_pkg.sv
// Constants and types for the flash block protect and program sequencer.
package flash_protect_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the register bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] PROTECT_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] TARGET_OFFSET = 8'h0C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_PROG_BIT = 0;
	localparam int CTRL_ERASE_BIT = 1;
	localparam int CTRL_MASS_BIT = 2;
	localparam int CTRL_HV_BIT = 3;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_REFUSED_BIT = 4;
	localparam int STAT_STANDBY_BIT = 5;
	localparam int STAT_PROTECTED_BIT = 6;

	// ----------------------------------------------------------------
	// Protect address construction and special values
	// ----------------------------------------------------------------
	localparam logic [1:0] START_HIGH_BITS = 2'h3;
	localparam logic [5:0] START_LOW_BITS = 6'h00;
	localparam logic [7:0] PROTECT_NONE = 8'hFF;
	localparam logic [7:0] PROTECT_ALL = 8'h00;
	localparam logic [7:0] PROTECT_VECTORS_ONLY = 8'hFE;
	localparam logic [7:0] PROTECT_BYTE_AND_VECTORS = 8'hFD;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [15:0] TARGET_RESET = 16'h0000;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

	// Flash control bits, most significant first.
	typedef struct packed {
		logic hv;
		logic mass;
		logic erase;
		logic prog;
	} ctrl_t;

	// Observed array-side access of the processor.
	typedef struct packed {
		logic wr;
		logic [15:0] addr;
	} array_access_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SELECTED,
		ST_BYTE_READ,
		ST_ADDR_LATCHED,
		ST_HIGH_VOLTAGE
	} seq_state_t;

endpackage

// >>> flash_protect_seq.sv
// Flash program and erase sequencer with block protection and a Wishbone register slave.
`timescale 1ns/10ps

module flash_protect_seq (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Array side and system status.
	input wire flash_protect_pkg::array_access_t array_i,
	input wire logic [7:0] protect_start_bits_i,
	input wire logic test_high_voltage_i,
	input wire logic low_power_i,
	// Flash control outputs.
	output flash_protect_pkg::ctrl_t flash_ctrl_o,
	output logic standby_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Start address from the protect bits; the low six zeros give 64-byte pages.
	function automatic logic [15:0] start_addr(input logic [7:0] bits);
		start_addr = {flash_protect_pkg::START_HIGH_BITS, bits,
			flash_protect_pkg::START_LOW_BITS};
	endfunction

	// True when an address is inside the protected range.
	function automatic logic in_protected(input logic [15:0] addr, input logic [7:0] bits);
		if (bits == flash_protect_pkg::PROTECT_NONE) begin
			in_protected = 1'b0;
		end else begin
			// All zeros gives C000, the array bottom, so everything is covered.
			in_protected = (addr >= start_addr(bits));
		end
	endfunction

	// ----------------------------------------------------------------
	// Registers and decode
	// ----------------------------------------------------------------
	flash_protect_pkg::ctrl_t ctrl_q;
	flash_protect_pkg::ctrl_t wr_ctrl;
	flash_protect_pkg::seq_state_t state_q;
	logic [15:0] addr_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic refused_q;
	logic standby_q;
	logic req;
	logic ctrl_wr;
	logic status_wr;
	logic protect_rd;
	logic blocked;
	logic hv_allowed;
	logic hv_attempt;
	logic interlock_bad;

	// A request is taken once, in the cycle before its acknowledge.
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign ctrl_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == flash_protect_pkg::CTRL_OFFSET);
	assign status_wr = req && wb_we_i && wb_sel_i[0] &&
		(wb_adr_i == flash_protect_pkg::STATUS_OFFSET);
	// Reading the protect byte register is the protect-byte read step.
	assign protect_rd = req && !wb_we_i && (wb_adr_i == flash_protect_pkg::PROTECT_OFFSET);
	assign wr_ctrl = flash_protect_pkg::ctrl_t'(wb_dat_i[3:0]);
	assign interlock_bad = wr_ctrl.prog && wr_ctrl.erase;
	assign hv_attempt = ctrl_wr && !interlock_bad && wr_ctrl.hv && !ctrl_q.hv;

	// Protection check; the test voltage opens every protectable location.
	always_comb begin
		if (test_high_voltage_i) begin
			blocked = 1'b0;
		end else if (ctrl_q.erase && ctrl_q.mass) begin
			blocked = (protect_start_bits_i != flash_protect_pkg::PROTECT_NONE);
		end else begin
			blocked = in_protected(addr_q, protect_start_bits_i);
		end
	end

	// High voltage needs a select bit and the full sequence up to the address latch.
	assign hv_allowed = (state_q == flash_protect_pkg::ST_ADDR_LATCHED) &&
		(ctrl_q.prog || ctrl_q.erase) && !blocked;

	// ----------------------------------------------------------------
	// Flash control register
	// ----------------------------------------------------------------

	// Low power aborts at once; a refused high voltage leaves the bit clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= flash_protect_pkg::CTRL_RESET;
		end else if (low_power_i) begin
			ctrl_q <= flash_protect_pkg::CTRL_RESET;
		end else if (ctrl_wr && !interlock_bad) begin
			ctrl_q.prog <= wr_ctrl.prog;
			ctrl_q.erase <= wr_ctrl.erase;
			ctrl_q.mass <= wr_ctrl.mass;
			if (hv_attempt) begin
				ctrl_q.hv <= hv_allowed;
			end else begin
				ctrl_q.hv <= wr_ctrl.hv;
			end
		end
	end

	// Sticky refusal flag; a new refusal in the clearing cycle wins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			refused_q <= 1'b0;
		end else if ((hv_attempt && !hv_allowed) || (ctrl_wr && interlock_bad)) begin
			refused_q <= 1'b1;
		end else if (status_wr && wb_dat_i[flash_protect_pkg::STAT_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// Standby holds from an abort until software selects a new operation.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			standby_q <= 1'b0;
		end else if (low_power_i && (state_q != flash_protect_pkg::ST_IDLE)) begin
			standby_q <= 1'b1;
		end else if (ctrl_q.prog || ctrl_q.erase) begin
			standby_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Sequence tracking
	// ----------------------------------------------------------------

	// Dropping both select bits before high voltage restarts the sequence.
	always_ff @(posedge clk_i) begin
		if (rst_i || low_power_i) begin
			state_q <= flash_protect_pkg::ST_IDLE;
		end else begin
			case (state_q)
				flash_protect_pkg::ST_IDLE: begin
					if (ctrl_q.prog || ctrl_q.erase) begin
						state_q <= flash_protect_pkg::ST_SELECTED;
					end
				end
				flash_protect_pkg::ST_SELECTED: begin
					if (!(ctrl_q.prog || ctrl_q.erase)) begin
						state_q <= flash_protect_pkg::ST_IDLE;
					end else if (protect_rd) begin
						state_q <= flash_protect_pkg::ST_BYTE_READ;
					end
				end
				flash_protect_pkg::ST_BYTE_READ: begin
					if (!(ctrl_q.prog || ctrl_q.erase)) begin
						state_q <= flash_protect_pkg::ST_IDLE;
					end else if (array_i.wr) begin
						state_q <= flash_protect_pkg::ST_ADDR_LATCHED;
					end
				end
				flash_protect_pkg::ST_ADDR_LATCHED: begin
					if (ctrl_q.hv) begin
						state_q <= flash_protect_pkg::ST_HIGH_VOLTAGE;
					end else if (!(ctrl_q.prog || ctrl_q.erase)) begin
						state_q <= flash_protect_pkg::ST_IDLE;
					end
				end
				flash_protect_pkg::ST_HIGH_VOLTAGE: begin
					if (!ctrl_q.hv) begin
						state_q <= flash_protect_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= flash_protect_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Only the first array write after the protect read picks the target.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_q <= flash_protect_pkg::TARGET_RESET;
		end else if ((state_q == flash_protect_pkg::ST_BYTE_READ) && array_i.wr) begin
			addr_q <= array_i.addr;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone answer
	// ----------------------------------------------------------------

	// One wait state: ack one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Read data is captured with the request; unmapped offsets read zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= flash_protect_pkg::DATA_RESET;
		end else if (req && !wb_we_i) begin
			if (wb_adr_i == flash_protect_pkg::CTRL_OFFSET) begin
				rdata_q <= {28'h000_0000, ctrl_q};
			end else if (wb_adr_i == flash_protect_pkg::PROTECT_OFFSET) begin
				rdata_q <= {24'h00_0000, protect_start_bits_i};
			end else if (wb_adr_i == flash_protect_pkg::STATUS_OFFSET) begin
				rdata_q <= {25'h000_0000, blocked, standby_q, refused_q, 1'b0, state_q};
			end else if (wb_adr_i == flash_protect_pkg::TARGET_OFFSET) begin
				rdata_q <= {16'h0000, addr_q};
			end else begin
				rdata_q <= flash_protect_pkg::DATA_RESET;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
	assign flash_ctrl_o = ctrl_q;
	assign standby_o = standby_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	chk_hv_after_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctrl_q.hv) |-> $past(state_q) == flash_protect_pkg::ST_ADDR_LATCHED)
		else $error("High voltage rose outside the latched step.");

	chk_hv_outside_range: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctrl_q.hv) && !$past(test_high_voltage_i) && !$past(ctrl_q.mass) |->
		!in_protected($past(addr_q), $past(protect_start_bits_i)))
		else $error("High voltage enabled on a protected address.");

	chk_mass_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctrl_q.hv) && $past(ctrl_q.mass) && $past(ctrl_q.erase) &&
		!$past(test_high_voltage_i) |->
		$past(protect_start_bits_i) == flash_protect_pkg::PROTECT_NONE)
		else $error("Mass erase started with a protected block.");

	chk_select_interlock: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_wr && interlock_bad && !low_power_i |=>
		$stable(ctrl_q) && !(ctrl_q.prog && ctrl_q.erase))
		else $error("Program and erase select both accepted.");

	chk_abort_standby: assert property (@(posedge clk_i) disable iff (rst_i)
		low_power_i && state_q != flash_protect_pkg::ST_IDLE |=>
		ctrl_q == flash_protect_pkg::CTRL_RESET && standby_o && state_q == flash_protect_pkg::ST_IDLE)
		else $error("Low power did not abort the operation.");

	chk_zero_protects: assert property (@(posedge clk_i) disable iff (rst_i)
		hv_attempt && protect_start_bits_i == flash_protect_pkg::PROTECT_ALL &&
		!test_high_voltage_i && !low_power_i |=> !ctrl_q.hv)
		else $error("High voltage allowed with the whole array protected.");

	chk_ones_open: assert property (@(posedge clk_i) disable iff (rst_i)
		hv_attempt && state_q == flash_protect_pkg::ST_ADDR_LATCHED && (ctrl_q.prog || ctrl_q.erase)
		&& protect_start_bits_i == flash_protect_pkg::PROTECT_NONE && !low_power_i |=> ctrl_q.hv)
		else $error("High voltage refused with no protection.");

	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Acknowledge was not a single pulse one cycle after the request.");

	chk_latch_first: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == flash_protect_pkg::ST_BYTE_READ && array_i.wr && (ctrl_q.prog || ctrl_q.erase)
		&& !low_power_i |=> addr_q == $past(array_i.addr))
		else $error("Target address was not latched.");

	cov_program_hv: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctrl_q.hv) && ctrl_q.prog);
	cov_mass_hv: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctrl_q.hv) && ctrl_q.mass);
	cov_refused: cover property (@(posedge clk_i) disable iff (rst_i) $rose(refused_q));
	cov_abort: cover property (@(posedge clk_i) disable iff (rst_i) $rose(standby_q));

endmodule
